// ---- logic/draw_engine_pkg.sv ----
`default_nettype none
package draw_engine_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	// Register byte offsets
	localparam logic [11:0] OFF_CONTROL = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_CUR_INFO = 12'h008;
	localparam logic [11:0] OFF_CUR_LENGTH = 12'h00c;
	localparam logic [11:0] OFF_CUR_COUNT = 12'h010;
	localparam logic [11:0] OFF_LAST_INFO = 12'h014;
	localparam logic [11:0] OFF_LAST_LENGTH = 12'h018;
	localparam logic [11:0] OFF_LAST_COUNT = 12'h01c;
	localparam logic [11:0] OFF_KEY_UPPER = 12'h020;
	localparam logic [11:0] OFF_KEY_LOWER = 12'h024;
	localparam logic [11:0] OFF_KEY_CONFIG = 12'h028;
	// Field positions
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_RESTART_BIT = 1;
	localparam int CTRL_ABORT_BIT = 2;
	localparam int CFG_KEY_EN_BIT = 0;
	localparam int CFG_BPP_LSB = 4;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_ERR_LSB = 8;
	// Values
	localparam logic [3:0] ERR_NONE = 4'h0;
	localparam logic [3:0] ERR_ABORT_NO_CMD = 4'he;
	localparam logic [3:0] ERR_ABORT_IN_CMD = 4'hf;
	localparam logic [31:0] FIFO_READ_BYTES = 32'h0000_0004;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [7:0] MASK_FULL = 8'hff;
	localparam logic [7:0] MASK_TOP5 = 8'hf8;
	localparam logic [7:0] MASK_TOP6 = 8'hfc;
	localparam logic [7:0] MASK_NONE = 8'h00;
	typedef enum logic [1:0] {
		PARSE_IDLE = 2'b00,
		PARSE_ACTIVE = 2'b01,
		PARSE_STALL = 2'b10
	} parser_state_t;
	typedef enum logic [1:0] {
		BPP_8 = 2'b00,
		BPP_16 = 2'b01,
		BPP_24 = 2'b10
	} pixel_depth_t;
	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} rgb_t;
	typedef struct packed {
		logic [31:0] info;
		logic [31:0] length;
		logic [31:0] byteCount;
	} cmd_record_t;
endpackage
`default_nettype wire

// ---- logic/draw_engine_status.sv ----
// Local design decision: the APB slave port.
`default_nettype none
module draw_engine_status
	import draw_engine_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fifoValid,
	input wire logic [31:0] fifoData,
	output logic fifoRead,
	input wire logic bodyRead,
	input wire logic cmdDone,
	input wire logic cmdError,
	input wire logic [3:0] cmdErrorCode,
	input wire rgb_t pixel,
	output logic chromaMatch,
	output parser_state_t parserState
);
	logic engineRunEnable_q;
	logic enablePrev_q;
	logic abortPulse_q;
	logic restartPulse_q;
	logic gotCmd_q;
	logic [3:0] errorCode_q;
	logic keyEnable_q;
	pixel_depth_t depth_q;
	rgb_t keyUpper_q;
	rgb_t keyLower_q;
	cmd_record_t current_q;
	cmd_record_t lastDone_q;
	parser_state_t state_q;
	logic [DATA_W-1:0] rdata_q;
	logic matchValue_d;
	logic chromaMatch_q;
	logic apbAccess;
	logic apbWrite;
	logic mapped;
	logic enableRise;
	logic clearRecords;
	logic doneNow;
	rgb_t maskSel;

	function automatic logic inRange(input logic [7:0] val, input logic [7:0] lo,
			input logic [7:0] hi, input logic [7:0] mask);
		inRange = ((val & mask) <= (hi & mask)) && ((val & mask) >= (lo & mask));
	endfunction

	function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
		isMapped = (addr == OFF_CONTROL) || (addr == OFF_STATUS) || (addr == OFF_CUR_INFO) ||
			(addr == OFF_CUR_LENGTH) || (addr == OFF_CUR_COUNT) ||
			(addr == OFF_LAST_INFO) || (addr == OFF_LAST_LENGTH) ||
			(addr == OFF_LAST_COUNT) || (addr == OFF_KEY_UPPER) ||
			(addr == OFF_KEY_LOWER) || (addr == OFF_KEY_CONFIG);
	endfunction

	// Zero-wait slave; read data is captured in the setup cycle
	assign pready = 1'b1;
	assign mapped = isMapped(paddr);
	assign apbAccess = psel && penable;
	assign apbWrite = apbAccess && pwrite && mapped;
	assign pslverr = apbAccess && !mapped;
	assign prdata = rdata_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= WORD_RESET;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				OFF_CONTROL: rdata_q <= {31'h0000_0000, engineRunEnable_q};
				OFF_STATUS: rdata_q <= {20'h0_0000, errorCode_q, 6'h00, state_q};
				OFF_CUR_INFO: rdata_q <= current_q.info;
				OFF_CUR_LENGTH: rdata_q <= current_q.length;
				OFF_CUR_COUNT: rdata_q <= current_q.byteCount;
				OFF_LAST_INFO: rdata_q <= lastDone_q.info;
				OFF_LAST_LENGTH: rdata_q <= lastDone_q.length;
				OFF_LAST_COUNT: rdata_q <= lastDone_q.byteCount;
				OFF_KEY_UPPER: rdata_q <= {8'h00, keyUpper_q};
				OFF_KEY_LOWER: rdata_q <= {8'h00, keyLower_q};
				OFF_KEY_CONFIG: rdata_q <= {26'h000_0000, depth_q, 3'h0, keyEnable_q};
				default: rdata_q <= WORD_RESET;
			endcase
		end
	end

	// Control bits; abort and restart never store, they fire for one cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			engineRunEnable_q <= 1'b0;
			enablePrev_q <= 1'b0;
			abortPulse_q <= 1'b0;
			restartPulse_q <= 1'b0;
		end else begin
			enablePrev_q <= engineRunEnable_q;
			abortPulse_q <= apbWrite && paddr == OFF_CONTROL && pwdata[CTRL_ABORT_BIT];
			restartPulse_q <= apbWrite && paddr == OFF_CONTROL && pwdata[CTRL_RESTART_BIT];
			if (apbWrite && paddr == OFF_CONTROL) begin
				engineRunEnable_q <= pwdata[CTRL_ENABLE_BIT];
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			keyUpper_q <= '0;
			keyLower_q <= '0;
			keyEnable_q <= 1'b0;
			depth_q <= BPP_24;
		end else if (apbWrite) begin
			if (paddr == OFF_KEY_UPPER) begin
				keyUpper_q <= pwdata[23:0];
			end
			if (paddr == OFF_KEY_LOWER) begin
				keyLower_q <= pwdata[23:0];
			end
			if (paddr == OFF_KEY_CONFIG) begin
				keyEnable_q <= pwdata[CFG_KEY_EN_BIT];
				// Reserved depth code falls back to full compare
				depth_q <= (pwdata[CFG_BPP_LSB+:2] == 2'b11) ? BPP_24 :
					pixel_depth_t'(pwdata[CFG_BPP_LSB+:2]);
			end
		end
	end

	assign enableRise = engineRunEnable_q && !enablePrev_q;
	assign clearRecords = restartPulse_q || enableRise;
	// Header words are popped by the parser, body words by the co-processor
	assign fifoRead = engineRunEnable_q && fifoValid && state_q == PARSE_IDLE &&
		!abortPulse_q && !clearRecords;
	assign doneNow = state_q == PARSE_ACTIVE && cmdDone && !abortPulse_q && !cmdError &&
		!clearRecords;
	assign parserState = state_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= PARSE_IDLE;
			gotCmd_q <= 1'b0;
			errorCode_q <= ERR_NONE;
		end else if (restartPulse_q) begin
			state_q <= PARSE_IDLE;
			gotCmd_q <= 1'b0;
			errorCode_q <= ERR_NONE;
		end else if (abortPulse_q) begin
			state_q <= PARSE_STALL;
			gotCmd_q <= 1'b0;
			errorCode_q <= (state_q == PARSE_IDLE && !gotCmd_q) ? ERR_ABORT_NO_CMD :
				ERR_ABORT_IN_CMD;
		end else if (cmdError && state_q != PARSE_STALL) begin
			// Stalls at once, leftover FIFO words stay unread
			state_q <= PARSE_STALL;
			gotCmd_q <= 1'b0;
			errorCode_q <= cmdErrorCode;
		end else begin
			unique case (state_q)
				PARSE_IDLE: begin
					if (fifoRead) begin
						gotCmd_q <= !gotCmd_q;
						state_q <= gotCmd_q ? PARSE_ACTIVE : PARSE_IDLE;
					end
				end
				PARSE_ACTIVE: begin
					if (cmdDone) begin
						state_q <= PARSE_IDLE;
					end
				end
				PARSE_STALL: state_q <= PARSE_STALL;
				default: state_q <= PARSE_STALL;
			endcase
		end
	end

	// Current record; an abort leaves it frozen for the driver to inspect
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			current_q <= '0;
		end else if (clearRecords || doneNow) begin
			current_q <= '0;
		end else if (!abortPulse_q && fifoRead) begin
			if (!gotCmd_q) begin
				current_q.info <= fifoData;
				current_q.length <= WORD_RESET;
				current_q.byteCount <= FIFO_READ_BYTES;
			end else begin
				current_q.length <= fifoData;
				current_q.byteCount <= current_q.byteCount + FIFO_READ_BYTES;
			end
		end else if (!abortPulse_q && state_q == PARSE_ACTIVE && bodyRead) begin
			current_q.byteCount <= current_q.byteCount + FIFO_READ_BYTES;
		end
	end

	// Last-done record is loaded only on a clean completion and zeroed by restart or enable rise
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lastDone_q <= '0;
		end else if (clearRecords) begin
			lastDone_q <= '0;
		end else if (doneNow) begin
			lastDone_q.info <= current_q.info;
			lastDone_q.length <= current_q.length;
			lastDone_q.byteCount <= bodyRead ? current_q.byteCount + FIFO_READ_BYTES :
				current_q.byteCount;
		end
	end

	always_comb begin
		maskSel.red = MASK_FULL;
		maskSel.green = MASK_FULL;
		maskSel.blue = MASK_FULL;
		unique case (depth_q)
			BPP_8: begin
				maskSel.red = MASK_NONE;
				maskSel.green = MASK_NONE;
			end
			BPP_16: begin
				maskSel.red = MASK_TOP5;
				maskSel.green = MASK_TOP6;
				maskSel.blue = MASK_TOP5;
			end
			BPP_24: maskSel.red = MASK_FULL;
			default: maskSel.red = MASK_FULL;
		endcase
		matchValue_d = keyEnable_q &&
			inRange(pixel.red, keyLower_q.red, keyUpper_q.red, maskSel.red) &&
			inRange(pixel.green, keyLower_q.green, keyUpper_q.green, maskSel.green) &&
			inRange(pixel.blue, keyLower_q.blue, keyUpper_q.blue, maskSel.blue);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			chromaMatch_q <= 1'b0;
		end else begin
			chromaMatch_q <= matchValue_d;
		end
	end
	assign chromaMatch = chromaMatch_q;

	abort_stall_a: assert property (@(posedge clk) disable iff (!arst_n)
		abortPulse_q && !restartPulse_q |=> state_q == PARSE_STALL &&
		(errorCode_q == ERR_ABORT_NO_CMD || errorCode_q == ERR_ABORT_IN_CMD))
		else $error("abort did not stall with code 14 or 15");
	abort_null_a: assert property (@(posedge clk) disable iff (!arst_n)
		abortPulse_q && !clearRecords && state_q == PARSE_IDLE && !gotCmd_q |=>
		errorCode_q == ERR_ABORT_NO_CMD && current_q == $past(current_q))
		else $error("abort without command did not report 14");
	abort_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
		abortPulse_q && !clearRecords |=> lastDone_q == $past(lastDone_q))
		else $error("abort disturbed last-done record");
	clear_rec_a: assert property (@(posedge clk) disable iff (!arst_n)
		clearRecords |=> lastDone_q.length == WORD_RESET && lastDone_q.byteCount == WORD_RESET)
		else $error("records not cleared on restart or enable rise");
	count_step_a: assert property (@(posedge clk) disable iff (!arst_n)
		fifoRead && gotCmd_q |=> current_q.byteCount == $past(current_q.byteCount) + 32'h0000_0004)
		else $error("byte count did not step by four");
	done_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
		doneNow |=> current_q.length == WORD_RESET && lastDone_q.length == $past(current_q.length))
		else $error("completion did not move length record");
	active_entry_a: assert property (@(posedge clk) disable iff (!arst_n)
		fifoRead && gotCmd_q && !cmdError |=> state_q == PARSE_ACTIVE)
		else $error("length word did not enter active");
	error_stall_a: assert property (@(posedge clk) disable iff (!arst_n)
		cmdError && state_q != PARSE_STALL && !abortPulse_q && !restartPulse_q |=>
		state_q == PARSE_STALL && errorCode_q == $past(cmdErrorCode))
		else $error("command error did not stall");
	pulse_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
		abortPulse_q && !(apbWrite && paddr == OFF_CONTROL) |=> !abortPulse_q)
		else $error("abort pulse lasted more than one cycle");
	key_store_a: assert property (@(posedge clk) disable iff (!arst_n)
		apbWrite && paddr == OFF_KEY_UPPER |=> keyUpper_q == $past(pwdata[23:0]))
		else $error("upper key not stored");
	match_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
		!keyEnable_q |=> !chromaMatch)
		else $error("match raised while disabled");

	abort_mid_c: cover property (@(posedge clk) disable iff (!arst_n)
		abortPulse_q && state_q == PARSE_ACTIVE);
	done_cmd_c: cover property (@(posedge clk) disable iff (!arst_n) doneNow);
	match_16_c: cover property (@(posedge clk) disable iff (!arst_n)
		depth_q == BPP_16 && chromaMatch);
	restart_c: cover property (@(posedge clk) disable iff (!arst_n)
		state_q == PARSE_STALL ##1 restartPulse_q);
endmodule
`default_nettype wire

// ---- tb/cmd_fifo_model.sv ----
`default_nettype none
module cmd_fifo_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic fifoRead,
	input wire logic fifoFlush,
	output logic fifoValid,
	output logic [31:0] fifoData
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] words[$];
	logic [31:0] lastWord = 32'h0000_0000;
	logic slow = 1'b0;
	logic gap = 1'b1;
	task automatic load(input logic [31:0] w);
		words.push_back(w);
	endtask
	// Outputs move only on the edge, so a load shows up one cycle later
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			words.delete();
			fifoValid <= 1'b0;
			fifoData <= ~lastWord;
		end else begin
			if (fifoFlush) begin
				words.delete();
			end else if (fifoRead && fifoValid) begin
				lastWord = words.pop_front();
			end
			// Slow host offers a word only every other cycle
			gap = slow ? ~gap : 1'b1;
			fifoValid <= gap && words.size() > 0;
			// Empty head shows the inverse of the last word, not stale data
			fifoData <= (gap && words.size() > 0) ? words[0] : ~lastWord;
		end
	end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`default_nettype none
module testbench
	import draw_engine_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic fifoValid;
	logic [31:0] fifoData;
	logic fifoRead;
	logic fifoFlush = 1'b0;
	logic bodyRead = 1'b0;
	logic cmdDone = 1'b0;
	logic cmdError = 1'b0;
	logic [3:0] cmdErrorCode = 4'h0;
	rgb_t pixel = '0;
	logic chromaMatch;
	parser_state_t parserState;
	int checks = 0;
	int err_total = 0;
	logic [31:0] q;
	logic e;
	logic [23:0] pix[5] = '{24'h3e_7e18, 24'h39_7e18, 24'h00_0018, 24'h3e_7e30, 24'h40_8020};
	logic [4:0] hits[3] = '{5'h17, 5'h13, 5'h11};
	always #2.5 clk = ~clk;
	draw_engine_status draw_engine_status_inst (.clk(clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fifoValid(fifoValid), .fifoData(fifoData),
		.fifoRead(fifoRead), .bodyRead(bodyRead), .cmdDone(cmdDone), .cmdError(cmdError),
		.cmdErrorCode(cmdErrorCode), .pixel(pixel), .chromaMatch(chromaMatch),
		.parserState(parserState));
	cmd_fifo_model cmd_fifo_model_inst (.clk(clk), .arst_n(arst_n), .fifoRead(fifoRead),
		.fifoFlush(fifoFlush), .fifoValid(fifoValid), .fifoData(fifoData));
	task automatic complete_run();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// Waits for pready however long it takes; only the watchdog ends a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, exp);
	endtask
	// Control pulses act one edge after the write; the task waits two
	task automatic ctl(input logic [31:0] d);
		apb(1'b1, OFF_CONTROL, d);
		repeat (2) @(posedge clk);
	endtask
	task automatic ev(input logic b, input logic d, input logic x, input logic [3:0] c = 4'h0);
		@(posedge clk);
		bodyRead <= b;
		cmdDone <= d;
		cmdError <= x;
		cmdErrorCode <= c;
		@(posedge clk);
		bodyRead <= 1'b0;
		cmdDone <= 1'b0;
		cmdError <= 1'b0;
	endtask
	task automatic wait_state(input parser_state_t s);
		int n = 0;
		while (parserState !== s && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk(32'(parserState), 32'(s));
	endtask
	task automatic flush();
		@(posedge clk);
		fifoFlush <= 1'b1;
		@(posedge clk);
		fifoFlush <= 1'b0;
	endtask
	function automatic logic [31:0] st(input logic [1:0] s, input logic [3:0] c);
		return (32'(c) << STAT_ERR_LSB) | (32'(s) << STAT_STATE_LSB);
	endfunction
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		$display("unexpected at %0t: watchdog expired", $time);
		complete_run();
	end
	initial begin
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		rd(OFF_LAST_LENGTH, 32'h0000_0000);
		rd(OFF_LAST_COUNT, 32'h0000_0000);
		rd(OFF_KEY_UPPER, 32'h0000_0000);
		rd(OFF_KEY_LOWER, 32'h0000_0000);
		rd(OFF_STATUS, st(PARSE_IDLE, ERR_NONE));
		rd(12'h100, 32'h0000_0000);
		chk({31'b0, e}, 32'h0000_0001);
		apb(1'b1, OFF_LAST_LENGTH, 32'hffff_ffff);
		rd(OFF_LAST_LENGTH, 32'h0000_0000);
		apb(1'b1, OFF_KEY_UPPER, 32'hff40_8020);
		rd(OFF_KEY_UPPER, 32'h0040_8020);
		apb(1'b1, OFF_KEY_LOWER, 32'hff3c_7c10);
		rd(OFF_KEY_LOWER, 32'h003c_7c10);
		for (int m = 0; m < 3; m++) begin
			apb(1'b1, OFF_KEY_CONFIG, (32'(m) << CFG_BPP_LSB) | 32'h0000_0001);
			for (int p = 0; p < 5; p++) begin
				@(posedge clk);
				pixel <= pix[p];
				@(posedge clk);
				@(negedge clk);
				chk({31'b0, chromaMatch}, {31'b0, hits[m][p]});
			end
		end
		apb(1'b1, OFF_KEY_CONFIG, 32'h0000_0020);
		repeat (2) @(negedge clk);
		chk({31'b0, chromaMatch}, 32'h0000_0000);
		ctl(32'h0000_0001);
		cmd_fifo_model_inst.load(32'h0000_00a5);
		repeat (4) @(posedge clk);
		rd(OFF_STATUS, st(PARSE_IDLE, ERR_NONE));
		rd(OFF_CUR_COUNT, 32'h0000_0004);
		cmd_fifo_model_inst.load(32'h0000_0003);
		wait_state(PARSE_ACTIVE);
		repeat (3) ev(1'b1, 1'b0, 1'b0);
		rd(OFF_CUR_COUNT, 32'h0000_0014);
		ev(1'b0, 1'b1, 1'b0);
		wait_state(PARSE_IDLE);
		rd(OFF_LAST_LENGTH, 32'h0000_0003);
		rd(OFF_LAST_COUNT, 32'h0000_0014);
		rd(OFF_CUR_LENGTH, 32'h0000_0000);
		cmd_fifo_model_inst.slow = 1'b1;
		cmd_fifo_model_inst.load(32'h0000_00b7);
		cmd_fifo_model_inst.load(32'h0000_0005);
		wait_state(PARSE_ACTIVE);
		ev(1'b1, 1'b0, 1'b0);
		ctl(32'h0000_0005);
		rd(OFF_STATUS, st(PARSE_STALL, ERR_ABORT_IN_CMD));
		rd(OFF_CONTROL, 32'h0000_0001);
		rd(OFF_CUR_INFO, 32'h0000_00b7);
		rd(OFF_CUR_COUNT, 32'h0000_000c);
		rd(OFF_LAST_COUNT, 32'h0000_0014);
		// Bus masters sit outside; a settle time stands in for their idle poll
		repeat (4) @(posedge clk);
		ctl(32'h0000_0000);
		flush();
		ctl(32'h0000_0002);
		rd(OFF_STATUS, st(PARSE_IDLE, ERR_NONE));
		rd(OFF_LAST_LENGTH, 32'h0000_0000);
		rd(OFF_LAST_COUNT, 32'h0000_0000);
		ctl(32'h0000_0001);
		chk({31'b0, fifoValid}, 32'h0000_0000);
		ctl(32'h0000_0005);
		rd(OFF_STATUS, st(PARSE_STALL, ERR_ABORT_NO_CMD));
		rd(OFF_CUR_INFO, 32'h0000_0000);
		ctl(32'h0000_0003);
		cmd_fifo_model_inst.slow = 1'b0;
		// Length word is followed by body words left queued
		foreach (pix[i]) cmd_fifo_model_inst.load({8'h00, pix[i]});
		wait_state(PARSE_ACTIVE);
		ev(1'b0, 1'b0, 1'b1, 4'h3);
		rd(OFF_STATUS, st(PARSE_STALL, 4'h3));
		chk({31'b0, fifoValid}, 32'h0000_0001);
		flush();
		ctl(32'h0000_0003);
		cmd_fifo_model_inst.load(32'h0000_00d1);
		cmd_fifo_model_inst.load(32'h0000_0001);
		wait_state(PARSE_ACTIVE);
		ev(1'b1, 1'b0, 1'b0);
		ev(1'b0, 1'b1, 1'b0);
		rd(OFF_LAST_LENGTH, 32'h0000_0001);
		ctl(32'h0000_0000);
		ctl(32'h0000_0001);
		rd(OFF_LAST_LENGTH, 32'h0000_0000);
		complete_run();
	end
endmodule
`default_nettype wire
